// ==== ioe_lib.sv ====
// Package of constants and the per-channel averaging filter of the integrated I/O front end
package ioe_pkg;
	localparam int NDI = 24;
	localparam int NDO = 16;
	localparam int NAI = 5;
	localparam int NAO = 2;
	localparam int DI_REC_LEN = 10;
	localparam int AI_REC_LEN = 13;
	localparam int DI_RSV_BYTE = 3;
	localparam int DI_FALL_BYTE = 4;
	localparam int DI_DLY_BYTE = 7;
	localparam int AO_BYTE = 5;
	localparam logic [7:0] A_DIREC = 8'h10;
	localparam logic [7:0] A_DIREC_END = 8'h1c;
	localparam logic [7:0] A_AIREC = 8'h20;
	localparam logic [7:0] A_AIREC_END = 8'h30;
	localparam logic [7:0] A_AIW = 8'h40;
	localparam logic [7:0] A_AIW_END = 8'h54;
	localparam logic [7:0] A_DIVAL = 8'h60;
	localparam logic [7:0] A_STAT = 8'h64;
	localparam logic [7:0] A_MASK = 8'h68;
	localparam logic [7:0] A_HINFO = 8'h6c;
	localparam logic [7:0] A_AOV0 = 8'h70;
	localparam logic [7:0] A_AOV1 = 8'h74;
	localparam logic [7:0] A_DO = 8'h78;
	localparam logic [7:0] A_CLAIM = 8'h7c;
	// Record reset images, byte 0 in the low bits
	localparam logic [79:0] DI_REC_RST = 80'h00002a00000000000000;
	localparam logic [103:0] AI_REC_RST = 104'h00000000000014144a4a4a4a4a;
	localparam logic [1:0] REJ_60 = 2'h1;
	localparam logic [1:0] REJ_50 = 2'h2;
	localparam logic [4:0] WIN_50 = 5'h14;
	localparam logic [4:0] WIN_60 = 5'h11;
	localparam logic [4:0] WIN_RAW = 5'h00;
	localparam int AVG_DEPTH = 20;
	localparam logic [3:0] AO_RANGE_OFF = 4'h0;
	localparam logic [1:0] AO_TYPE_OFF = 2'h0;
	localparam logic [15:0] UNIT_ADDR = 16'h007c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_MHZ = 125;
	localparam int SAMPLE_US = 1000;
	localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
	localparam int DLY_TICK_US = 100;
	localparam int DLY_TICK_CYC = DLY_TICK_US * CLK_MHZ;
	// Input delay in 0.1 ms ticks for codes 0..3: 0.1, 0.5, 3, 15 ms
	localparam logic [3:0][7:0] DLY_UNITS = {8'h96, 8'h1e, 8'h05, 8'h01};
endpackage

module ioe_avg (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic smp_stb,
	input wire logic [15:0] smp_data,
	input wire logic [4:0] win,
	output logic [15:0] avg_q
);
	typedef struct packed {
		logic [4:0] wr;
		logic [4:0] fill;
		logic [4:0] win;
		logic signed [21:0] sum;
		logic [15:0] out;
	} ioe_avg_s;

	ioe_avg_s s;
	ioe_avg_s d;
	logic [15:0] mem [ioe_pkg::AVG_DEPTH];
	logic [5:0] old;
	logic signed [21:0] nsum;
	logic signed [21:0] quo;
	logic [4:0] div;

	// Running sum over the last win samples, raw pass-through while filling
	always_comb begin
		d = s;
		old = 6'(s.wr) + 6'(ioe_pkg::AVG_DEPTH) - 6'(win);
		if (old >= 6'(ioe_pkg::AVG_DEPTH)) begin
			old = old - 6'(ioe_pkg::AVG_DEPTH);
		end
		nsum = s.sum + 22'(signed'(smp_data));
		if (s.fill == win) begin
			nsum = nsum - 22'(signed'(mem[old[4:0]])); // Oldest sample leaves
		end
		div = (win == ioe_pkg::WIN_RAW) ? 5'h01 : win;
		quo = nsum / $signed({17'h0, div});
		if (win != s.win) begin
			d.win = win; // Setting changed, restart window
			d.fill = '0;
			d.sum = '0;
		end else if (smp_stb) begin
			d.wr = (s.wr == 5'(ioe_pkg::AVG_DEPTH - 1)) ? 5'h00 : s.wr + 5'h01;
			if (win == ioe_pkg::WIN_RAW) begin
				d.out = smp_data;
			end else begin
				d.sum = nsum;
				if (s.fill != win) begin
					d.fill = s.fill + 5'h01;
				end
				d.out = (d.fill == win) ? quo[15:0] : smp_data;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= d;
		end
	end

	// Sample history
	always_ff @(posedge aclk) begin
		if (smp_stb) begin
			mem[s.wr] <= smp_data;
		end
	end

	assign avg_q = s.out;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	hold_value_a: assert property (!smp_stb && win == s.win |=> $stable(avg_q))
		else $error("measured value changed without a sample");
	raw_pass_a: assert property (smp_stb && win == ioe_pkg::WIN_RAW && s.win == win
		|=> avg_q == $past(smp_data))
		else $error("unfiltered setting did not pass the raw sample");
endmodule // ioe_avg

// ==== ioe_top.sv ====
// Integrated I/O front end: analog sampling, input delay, edge interrupts, AXI4-Lite registers
module ioe_top #(
	parameter int SAMPLE_CYC = ioe_pkg::SAMPLE_CYC,
	parameter int DLY_TICK_CYC = ioe_pkg::DLY_TICK_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic [23:0] digital_input,
	input wire logic [4:0][15:0] adc_data,
	output logic adc_start,
	input wire logic [15:0] tf_output,
	output logic [15:0] digital_output,
	output logic [1:0][15:0] analog_output,
	output logic [1:0] analog_output_power,
	output logic process_interrupt_flag
);
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [9:0][7:0] di_rec;
		logic [12:0][7:0] ai_rec;
		logic [1:0][15:0] ao_val;
		logic [1:0][15:0] ao_out;
		logic [1:0] ao_pwr;
		logic [15:0] do_reg;
		logic [15:0] claim;
		logic [15:0] dout;
		logic [23:0] mask;
		logic [23:0] stat;
		logic irq;
		logic [23:0] s1;
		logic [23:0] s2;
		logic [23:0] filt;
		logic [23:0][7:0] dcnt;
		logic [16:0] dtk;
		logic dtick;
		logic [16:0] stk;
		logic smp_stb;
		logic [4:0][15:0] raw;
	} ioe_top_s;

	ioe_top_s s;
	ioe_top_s d;
	logic [23:0] ev;
	logic [23:0] clr;
	logic [23:0] rise;
	logic [23:0] fall;
	logic [31:0] bm;
	logic [31:0] rword;
	logic [7:0] lim;
	logic [15:0] nd;
	logic wr_fire;
	logic [4:0][15:0] ai_word;
	logic [4:0][4:0] win;

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && ((a >= ioe_pkg::A_DIREC && a < ioe_pkg::A_DIREC_END)
			|| (a >= ioe_pkg::A_AIREC && a < ioe_pkg::A_AIREC_END)
			|| (a >= ioe_pkg::A_AIW && a < ioe_pkg::A_AIW_END)
			|| (a >= ioe_pkg::A_DIVAL && a <= ioe_pkg::A_CLAIM));
	endfunction

	// Rejection setting picks the averaging window per channel
	always_comb begin
		for (int c = 0; c < ioe_pkg::NAI; c++) begin
			unique case (s.ai_rec[c][1:0])
				ioe_pkg::REJ_50: win[c] = ioe_pkg::WIN_50;
				ioe_pkg::REJ_60: win[c] = ioe_pkg::WIN_60;
				default: win[c] = ioe_pkg::WIN_RAW;
			endcase
		end
	end

	// One averaging filter per analog input channel
	for (genvar c = 0; c < ioe_pkg::NAI; c++) begin : g_ai
		ioe_avg u_avg (
			.aclk(aclk),
			.aresetn(aresetn),
			.smp_stb(s.smp_stb),
			.smp_data(s.raw[c]),
			.win(win[c]),
			.avg_q(ai_word[c])
		);
	end

	// Next state of the whole block
	always_comb begin
		d = s;
		d.smp_stb = 1'b0;
		d.dtick = 1'b0;
		clr = '0;
		lim = '0;
		nd = '0;
		for (int k = 0; k < 4; k++) begin
			bm[8*k+:8] = {8{s.wstrb[k]}};
		end
		rise = {s.di_rec[2], s.di_rec[1], s.di_rec[0]};
		fall = {s.di_rec[6], s.di_rec[5], s.di_rec[4]};

		// Read data mux
		rword = '0;
		for (int b = 0; b < ioe_pkg::DI_REC_LEN; b++) begin
			if (s_axi_araddr[7:2] == 6'(ioe_pkg::A_DIREC[7:2] + 6'(b / 4))) begin
				rword[8*(b%4)+:8] = s.di_rec[b];
			end
		end
		for (int b = 0; b < ioe_pkg::AI_REC_LEN; b++) begin
			if (s_axi_araddr[7:2] == 6'(ioe_pkg::A_AIREC[7:2] + 6'(b / 4))) begin
				rword[8*(b%4)+:8] = s.ai_rec[b];
			end
		end
		for (int c = 0; c < ioe_pkg::NAI; c++) begin
			if (s_axi_araddr[7:2] == 6'(ioe_pkg::A_AIW[7:2] + 6'(c))) begin
				rword = {16'h0000, ai_word[c]};
			end
		end
		case (s_axi_araddr)
			ioe_pkg::A_DIVAL: rword = {8'h00, s.filt};
			ioe_pkg::A_STAT: rword = {8'h00, s.stat};
			ioe_pkg::A_MASK: rword = {8'h00, s.mask};
			ioe_pkg::A_HINFO: rword = {16'h0000, ioe_pkg::UNIT_ADDR};
			ioe_pkg::A_AOV0: rword = {16'h0000, s.ao_val[0]};
			ioe_pkg::A_AOV1: rword = {16'h0000, s.ao_val[1]};
			ioe_pkg::A_DO: rword = {16'h0000, s.do_reg};
			ioe_pkg::A_CLAIM: rword = {16'h0000, s.claim};
			default: ;
		endcase

		// Write address and data channels, taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_got = 1'b1;
			d.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		wr_fire = s.aw_got && s.w_got && !s.bvalid;
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = mapped(s.waddr) ? ioe_pkg::RESP_OKAY : ioe_pkg::RESP_SLVERR;
			// Records are writable at any time
			for (int b = 0; b < ioe_pkg::DI_REC_LEN; b++) begin
				if (s.waddr[7:2] == 6'(ioe_pkg::A_DIREC[7:2] + 6'(b / 4)) && s.wstrb[b%4]
					&& b != ioe_pkg::DI_RSV_BYTE) begin
					d.di_rec[b] = s.wdata[8*(b%4)+:8];
				end
			end
			for (int b = 0; b < ioe_pkg::AI_REC_LEN; b++) begin
				if (s.waddr[7:2] == 6'(ioe_pkg::A_AIREC[7:2] + 6'(b / 4)) && s.wstrb[b%4]) begin
					d.ai_rec[b] = s.wdata[8*(b%4)+:8];
				end
			end
			case (s.waddr)
				ioe_pkg::A_STAT: clr = s.wdata[23:0] & bm[23:0];
				ioe_pkg::A_MASK: d.mask = (s.mask & ~bm[23:0]) | (s.wdata[23:0] & bm[23:0]);
				ioe_pkg::A_AOV0: d.ao_val[0] = (s.ao_val[0] & ~bm[15:0]) | (s.wdata[15:0] & bm[15:0]);
				ioe_pkg::A_AOV1: d.ao_val[1] = (s.ao_val[1] & ~bm[15:0]) | (s.wdata[15:0] & bm[15:0]);
				ioe_pkg::A_CLAIM: d.claim = (s.claim & ~bm[15:0]) | (s.wdata[15:0] & bm[15:0]);
				ioe_pkg::A_DO: begin
					nd = (s.do_reg & ~bm[15:0]) | (s.wdata[15:0] & bm[15:0]);
					d.do_reg = (nd & ~s.claim) | (s.do_reg & s.claim);
				end
				default: ;
			endcase
		end

		// Read channel
		if (s_axi_rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			d.rvalid = 1'b1;
			d.rdata = rword;
			d.rresp = mapped(s_axi_araddr) ? ioe_pkg::RESP_OKAY : ioe_pkg::RESP_SLVERR;
		end

		// Millisecond sample strobe latches all converter words
		if (s.stk >= 17'(SAMPLE_CYC - 1)) begin
			d.stk = '0;
			d.smp_stb = 1'b1;
			d.raw = adc_data;
		end else begin
			d.stk = s.stk + 17'h00001;
		end

		// 0.1 ms tick for the input delay
		if (s.dtk >= 17'(DLY_TICK_CYC - 1)) begin
			d.dtk = '0;
			d.dtick = 1'b1;
		end else begin
			d.dtk = s.dtk + 17'h00001;
		end

		// Pin synchroniser
		d.s1 = digital_input;
		d.s2 = s.s1;

		// Input delay: a new level must persist for the group's delay
		for (int i = 0; i < ioe_pkg::NDI; i++) begin
			lim = ioe_pkg::DLY_UNITS[s.di_rec[ioe_pkg::DI_DLY_BYTE][2*(i/8)+:2]];
			if (s.s2[i] == s.filt[i]) begin
				d.dcnt[i] = '0;
			end else if (s.dtick) begin
				if (s.dcnt[i] + 8'h01 >= lim) begin
					d.filt[i] = s.s2[i];
					d.dcnt[i] = '0;
				end else begin
					d.dcnt[i] = s.dcnt[i] + 8'h01;
				end
			end
		end

		// Edge events into one sticky pending bit per channel, set beats clear
		ev = ((d.filt & ~s.filt) & rise) | ((s.filt & ~d.filt) & fall);
		d.stat = (s.stat & ~clr) | ev;
		d.irq = |(d.stat & d.mask);

		// Analog outputs, unpowered when range or type is off
		for (int k = 0; k < ioe_pkg::NAO; k++) begin
			d.ao_pwr[k] = s.ai_rec[ioe_pkg::AO_BYTE+k][3:0] != ioe_pkg::AO_RANGE_OFF
				&& s.ai_rec[ioe_pkg::AO_BYTE+k][5:4] != ioe_pkg::AO_TYPE_OFF;
			d.ao_out[k] = d.ao_pwr[k] ? s.ao_val[k] : 16'h0000;
		end

		// Claimed outputs follow the technological function
		d.dout = (s.do_reg & ~s.claim) | (tf_output & s.claim);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.di_rec <= ioe_pkg::DI_REC_RST;
			s.ai_rec <= ioe_pkg::AI_REC_RST;
		end else begin
			s <= d;
		end
	end

	// Outputs
	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready = !s.w_got && !s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign adc_start = s.smp_stb;
	assign digital_output = s.dout;
	assign analog_output = s.ao_out;
	assign analog_output_power = s.ao_pwr;
	assign process_interrupt_flag = s.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence both_taken_s;
		s.aw_got && s.w_got && !s.bvalid;
	endsequence
	sequence resp_up_s;
		s_axi_bvalid && !s_axi_awready && !s_axi_wready;
	endsequence

	write_resp_a: assert property (both_taken_s |=> resp_up_s)
		else $error("write response did not follow");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data did not follow");
	sample_period_a: assert property (s.smp_stb |-> $past(s.stk) == 17'(SAMPLE_CYC - 1))
		else $error("sample strobe off period");
	claimed_write_a: assert property (wr_fire && s.waddr == ioe_pkg::A_DO
		|=> ((s.do_reg ^ $past(s.do_reg)) & $past(s.claim)) == 16'h0000)
		else $error("claimed output bit changed by write");
	delay_tick_a: assert property (!s.dtick |=> $stable(s.filt))
		else $error("filtered input moved off tick");
	edge_pend_a: assert property (ev != 24'h0 |=> ($past(ev) & ~s.stat) == 24'h0)
		else $error("edge event not made pending");
	pend_keep_a: assert property (1'b1
		|=> (($past(s.stat) & ~$past(clr)) & ~s.stat) == 24'h0)
		else $error("pending event lost without clear");
	accept_clr_a: assert property (clr != 24'h0
		|=> (s.stat & $past(clr) & ~$past(ev)) == 24'h0)
		else $error("accepted event still pending");
	edge_enable_a: assert property ((ev & ~(rise | fall)) == 24'h0)
		else $error("event on disabled input");
	rsv_byte_a: assert property (s.di_rec[ioe_pkg::DI_RSV_BYTE] == 8'h00)
		else $error("reserved record byte not zero");
	irq_level_a: assert property (process_interrupt_flag == |(s.stat & s.mask))
		else $error("interrupt level does not match pending events");
	ao_unpowered_a: assert property (!analog_output_power[0]
		|-> analog_output[0] == 16'h0000)
		else $error("unpowered analog output not zero");
endmodule // ioe_top

// ==== ioe_field.sv ====
// Field side model: analog transducers and input contacts
module ioe_field (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic adc_start,
	input wire logic [23:0] di_level,
	output logic [4:0][15:0] adc_data,
	output logic [23:0] digital_input
);
	timeunit 1ns;
	timeprecision 1ps;
	logic phase_q;
	// Converter level swaps after every sample strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) phase_q <= 1'b0;
		else if (adc_start) phase_q <= ~phase_q;
	end
	// Base level per channel plus a swing of 0x28
	always_comb begin
		for (int c = 0; c < 5; c++) adc_data[c] = 16'((c + 1) * 256) + (phase_q ? 16'h0028 : 16'h0000);
	end
	// Contacts follow the requested levels
	assign digital_input = di_level;
endmodule // ioe_field

// ==== testbench.sv ====
// Self-checking bench of the integrated I/O front end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SMP = 20;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
	logic aw_r, w_r, b_v, ar_r, r_v, adc_start, irq;
	logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
	logic [31:0] w_d = 32'h0, r_d;
	logic [1:0] b_resp, r_resp, ao_pwr;
	logic [23:0] di_lvl = 24'h0, din;
	logic [4:0][15:0] adc;
	logic [15:0] tf_out = 16'h0, dout;
	logic [1:0][15:0] ao;
	int num_errors = 0, checks_done = 0;
	logic [31:0] v, v2;

	// Clock
	always #4 aclk = ~aclk;

	ioe_top #(.SAMPLE_CYC(SMP), .DLY_TICK_CYC(4)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
		.s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_bresp(b_resp),
		.s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0),
		.s_axi_rvalid(r_v), .s_axi_rready(r_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
		.digital_input(din), .adc_data(adc), .adc_start(adc_start), .tf_output(tf_out),
		.digital_output(dout), .analog_output(ao), .analog_output_power(ao_pwr),
		.process_interrupt_flag(irq));

	ioe_field field (.aclk(aclk), .aresetn(aresetn), .adc_start(adc_start), .di_level(di_lvl),
		.adc_data(adc), .digital_input(din));

	task automatic tally_and_finish();
		if (num_errors == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic give_up();
		num_errors++;
		tally_and_finish();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Register write, response code compared
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok, b_ok;
		logic [1:0] rs;
		int n;
		n = 0;
		@(posedge aclk); // Keeps bready from being assigned twice in one step
		aw_v <= 1'b1;
		aw_a <= a;
		w_v <= 1'b1;
		w_d <= d;
		b_rdy <= 1'b1;
		do begin
			@(negedge aclk);
			aw_ok = aw_v & aw_r;
			w_ok = w_v & w_r;
			b_ok = b_v;
			rs = b_resp;
			@(posedge aclk);
			if (aw_ok) aw_v <= 1'b0;
			if (w_ok) w_v <= 1'b0;
			if (b_ok) b_rdy <= 1'b0;
			n++;
			if (n > 50) give_up();
		end while (!b_ok);
		chk({30'h0, rs}, {30'h0, ioe_pkg::RESP_OKAY});
	endtask

	// Register read with expected response code
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		logic ar_ok, r_ok;
		logic [1:0] rs;
		int n;
		n = 0;
		@(posedge aclk); // Keeps rready from being assigned twice in one step
		ar_v <= 1'b1;
		ar_a <= a;
		r_rdy <= 1'b1;
		do begin
			@(negedge aclk);
			ar_ok = ar_v & ar_r;
			r_ok = r_v;
			d = r_d;
			rs = r_resp;
			@(posedge aclk);
			if (ar_ok) ar_v <= 1'b0;
			if (r_ok) r_rdy <= 1'b0;
			n++;
			if (n > 50) give_up();
		end while (!r_ok);
		chk({30'h0, rs}, {30'h0, er});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d, ioe_pkg::RESP_OKAY);
		chk(d, e);
	endtask

	// Wait for the sample strobe, then count cycles to the next one
	task automatic strobe_gap(output int m);
		int n;
		n = 0;
		m = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!adc_start && n < 200);
		do begin
			@(negedge aclk);
			m++;
		end while (!adc_start && m < 200);
		@(posedge aclk);
	endtask

	// Reset images, unmapped place, handler address
	task automatic t_defaults();
		logic [7:0] a[6] = '{8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h2c};
		logic [31:0] e[6] = '{32'h0, 32'h2a000000, 32'h0, 32'h4a4a4a4a, 32'h0014144a, 32'h0};
		foreach (a[i]) rd_chk(a[i], e[i]);
		chk({30'h0, ao_pwr}, 32'h3);
		rd_chk(ioe_pkg::A_HINFO, 32'h0000007c);
		rd(8'h00, v, ioe_pkg::RESP_SLVERR);
		chk(v, 32'h0);
	endtask

	// Sample rate, hold between samples, filter settings
	task automatic t_sampling();
		int m;
		strobe_gap(m);
		chk(m, SMP);
		wr(8'h20, 32'h4a49484a);
		cyc(25 * SMP);
		rd_chk(ioe_pkg::A_AIW, 32'h00000114);
		rd(8'h44, v, ioe_pkg::RESP_OKAY);
		chk({31'h0, v == 32'h200 || v == 32'h228}, 32'h1);
		rd(8'h48, v, ioe_pkg::RESP_OKAY);
		chk({31'h0, v > 32'h311 && v < 32'h316 && v != 32'h314}, 32'h1);
		strobe_gap(m);
		cyc(3);
		rd(8'h44, v, ioe_pkg::RESP_OKAY);
		rd(8'h44, v2, ioe_pkg::RESP_OKAY);
		chk(v2, v);
	endtask

	// Input delay, edge selection, pending events, acknowledge
	task automatic t_irq();
		wr(ioe_pkg::A_MASK, 32'h00ffffff);
		wr(8'h10, 32'hff000005);
		rd_chk(8'h10, 32'h00000005);
		wr(8'h14, 32'h28000006);
		di_lvl <= 24'h000100;
		cyc(100);
		rd_chk(ioe_pkg::A_DIVAL, 32'h0);
		cyc(45);
		rd_chk(ioe_pkg::A_DIVAL, 32'h00000100);
		di_lvl <= 24'h00000f;
		cyc(30);
		rd_chk(ioe_pkg::A_STAT, 32'h5);
		chk({31'h0, irq}, 32'h1);
		di_lvl <= 24'h0;
		cyc(30);
		rd_chk(ioe_pkg::A_STAT, 32'h7);
		wr(ioe_pkg::A_MASK, 32'h0);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		wr(ioe_pkg::A_MASK, 32'h00ffffff);
		wr(ioe_pkg::A_STAT, 32'h7);
		rd_chk(ioe_pkg::A_STAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		di_lvl <= 24'h000004;
		cyc(30);
		rd_chk(ioe_pkg::A_STAT, 32'h4);
		wr(ioe_pkg::A_STAT, 32'h4);
	endtask

	// Claimed outputs, filtered input value, analog output ranges
	task automatic t_outputs();
		tf_out <= 16'h00a5;
		wr(ioe_pkg::A_CLAIM, 32'h000000ff);
		wr(ioe_pkg::A_DO, 32'h0000ffff);
		cyc(20); // Slow input group has settled low by now
		chk({16'h0, dout}, 32'h0000ffa5);
		rd_chk(ioe_pkg::A_DIVAL, 32'h00000004);
		wr(ioe_pkg::A_AOV0, 32'h00001234);
		wr(ioe_pkg::A_AOV1, 32'h00005678);
		wr(8'h24, 32'h0014004a);
		cyc(3);
		chk({30'h0, ao_pwr}, 32'h2);
		chk({ao[1], ao[0]}, 32'h56780000);
	endtask

	// Main sequence
	initial begin
		cyc(10);
		aresetn <= 1'b1;
		cyc(1);
		t_defaults();
		t_sampling();
		t_irq();
		t_outputs();
		tally_and_finish();
	end
endmodule // testbench
